// *** rtl/fwpbm_pkg.sv ***
// Package for the flash write-protect and bank-map block.
// Assumes a 32-bit AXI4-Lite register bus and a 16-bit CPU address space.
package fwpbm_pkg;
	// Register byte offsets
	localparam logic [7:0] FLASH_CONTROL_OFS = 8'h00;
	localparam logic [7:0] MODE_STATUS_OFS = 8'h04;
	// Field positions in flash_control
	localparam int UNLOCK_LSB = 4;
	localparam int BANK_BIT = 3;
	// Command enable codes
	localparam logic [3:0] CODE_UNLOCKED = 4'h3;
	localparam logic [3:0] CODE_LOCKED = 4'hc;
	localparam logic BANK_RESET = 1'b0;
	// Address map
	localparam logic [15:0] FLASH_LO = 16'h1000;
	localparam logic [15:0] ROM_LO = 16'h7800;
	localparam logic [15:0] ROM_HI = 16'h7fff;
	localparam logic [15:0] WIN_LO = 16'h8000;
	localparam logic [15:0] LOWER_BANK_LO = 16'h9000;
	localparam logic [15:0] BANK_OFFSET = 16'h8000;
	localparam int CMD_MATCH_BITS = 12;
	// AXI response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Operating modes
	typedef enum logic [2:0] {
		FWPBM_MODE_CPU = 3'b001,
		FWPBM_MODE_SERIAL = 3'b010,
		FWPBM_MODE_PARALLEL = 3'b100
	} fwpbm_mode_t;
endpackage

// *** rtl/fwpbm_map_if.sv ***
// Carrier between the control core and the address mapper.
// Assumes both ends share one clock.
interface fwpbm_map_if;
	logic serial_mode;
	logic bank_sel;
	logic [15:0] cpu_addr;
	logic hit_flash;
	logic hit_rom;
	logic [15:0] flash_addr;
	modport core (output serial_mode, output bank_sel, output cpu_addr,
		input hit_flash, input hit_rom, input flash_addr);
	modport mapper (input serial_mode, input bank_sel, input cpu_addr,
		output hit_flash, output hit_rom, output flash_addr);
endinterface

// *** rtl/fwpbm_mapper.sv ***
// Combinational CPU-to-flash address decoder.
// Assumes mode and bank select come from registers in the core.
module fwpbm_mapper (
	// Map carrier
	fwpbm_map_if.mapper m
);
	always_comb begin
		m.hit_flash = 1'b0;
		m.hit_rom = 1'b0;
		m.flash_addr = m.cpu_addr;
		if (!m.serial_mode) begin
			m.hit_flash = (m.cpu_addr >= fwpbm_pkg::FLASH_LO); // see R06 see R13
		end else if (m.cpu_addr >= fwpbm_pkg::ROM_LO && m.cpu_addr <= fwpbm_pkg::ROM_HI) begin
			m.hit_rom = 1'b1; // see R09
		end else if (m.bank_sel) begin
			m.hit_flash = (m.cpu_addr >= fwpbm_pkg::WIN_LO); // see R11 see R12
		end else begin
			m.hit_flash = (m.cpu_addr >= fwpbm_pkg::LOWER_BANK_LO); // see R10 see R07
			m.flash_addr = m.cpu_addr - fwpbm_pkg::BANK_OFFSET;
		end
	end
endmodule

// *** rtl/fwpbm_cmd_gate.sv ***
// Command write gate toward the flash macro.
// Assumes the flash macro does its own sequence decoding.
module fwpbm_cmd_gate (
	// Control
	input wire logic unlocked,
	input wire logic parallel_mode,
	// CPU flash write
	input wire logic wr_req,
	input wire logic [15:0] wr_addr,
	input wire logic [7:0] wr_data,
	// To flash macro
	output logic cmd_wr,
	output logic [15:0] cmd_addr,
	output logic [11:0] cmd_match
);
	// Parallel mode writes never pass this gate; the writer drives the macro.
	assign cmd_wr = wr_req && unlocked && !parallel_mode; // see R01 see R14
	assign cmd_addr = wr_addr;
	assign cmd_match = wr_addr[fwpbm_pkg::CMD_MATCH_BITS-1:0]; // see R15
	logic unused_data;
	assign unused_data = ^wr_data;
endmodule

// *** rtl/fwpbm_top.sv ***
// Flash control: command lock, bank map and AXI4-Lite register slave.
// Assumes CPU flash access signals are synchronous to clk.
// Operation
// R01: Command sequences pass only while the enable field holds 0011B.
// R02: Writing 1100B locks the flash against command sequences.
// R03: Reset loads the enable field with 1100B.
// R04: Software writes only 1100B or 0011B to the enable field.
// R05: Software keeps the field locked except while programming or erasing.
// R06: CPU mode shows flash at 1000-FFFFH, bank select ignored.
// R07: Bank select affects decoding only in serial PROM mode.
// R08: Control bits 2 to 0 read as undefined values.
// R09: Serial mode maps 7800H-7FFFH to loader ROM, flash window above.
// R10: Bank 0 maps 9000H-FFFFH to flash 1000H-7FFFH.
// R11: Bank 1 maps 8000H-FFFFH onto flash 8000H-FFFFH.
// R12: Bank select 0 picks lower bank, 1 upper bank.
// R13: Flash holds 61440 bytes at 1000H to FFFFH.
// R14: Control covers CPU and serial modes, not parallel PROM mode.
// R15: Command addresses match on low 12 bits.
// R16: New bank select applies to the next access after the write.
module fwpbm_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Operating mode pins
	input wire logic serial_mode_pin,
	input wire logic parallel_mode_pin,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// CPU flash access
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic [7:0] cpu_wdata,
	output logic flash_sel,
	output logic rom_sel,
	output logic [15:0] flash_addr,
	// Flash macro command port
	output logic flash_cmd_wr,
	output logic [15:0] flash_cmd_addr,
	output logic [11:0] flash_cmd_match,
	output logic [7:0] flash_cmd_data
);
	////////////////////////////////////////////////////////////////////////
	// Mode pins
	logic [1:0] ser_sync_q;
	logic [1:0] par_sync_q;
	fwpbm_pkg::fwpbm_mode_t mode_q;

	// Straps are pins, so they pass two flops first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ser_sync_q <= 2'h0;
			par_sync_q <= 2'h0;
		end else begin
			ser_sync_q <= {ser_sync_q[0], serial_mode_pin};
			par_sync_q <= {par_sync_q[0], parallel_mode_pin};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_q <= fwpbm_pkg::FWPBM_MODE_CPU;
		end else if (par_sync_q[1]) begin
			mode_q <= fwpbm_pkg::FWPBM_MODE_PARALLEL;
		end else if (ser_sync_q[1]) begin
			mode_q <= fwpbm_pkg::FWPBM_MODE_SERIAL;
		end else begin
			mode_q <= fwpbm_pkg::FWPBM_MODE_CPU;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register decode
	function automatic logic is_ctrl(input logic [7:0] a);
		is_ctrl = (a[7:2] == fwpbm_pkg::FLASH_CONTROL_OFS[7:2]);
	endfunction

	function automatic logic is_stat(input logic [7:0] a);
		is_stat = (a[7:2] == fwpbm_pkg::MODE_STATUS_OFS[7:2]);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path
	logic aw_held_q;
	logic w_held_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic wr_fire;

	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready = !w_held_q && !bvalid_q;
	assign wr_fire = aw_held_q && w_held_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_held_q <= 1'b0;
			awaddr_q <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			w_held_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bvalid_q <= 1'b0;
			bresp_q <= fwpbm_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= (is_ctrl(awaddr_q) || is_stat(awaddr_q)) ?
				fwpbm_pkg::RESP_OKAY : fwpbm_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	////////////////////////////////////////////////////////////////////////
	// Control register
	logic [3:0] unlock_code_q;
	logic bank_sel_q;

	// Only the two defined codes are stored; anything else leaves it locked
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			unlock_code_q <= fwpbm_pkg::CODE_LOCKED; // see R03
		end else if (wr_fire && is_ctrl(awaddr_q) && wstrb_q[0]) begin
			if (wdata_q[fwpbm_pkg::UNLOCK_LSB +: 4] == fwpbm_pkg::CODE_UNLOCKED) begin
				unlock_code_q <= fwpbm_pkg::CODE_UNLOCKED; // see R01
			end else begin
				unlock_code_q <= fwpbm_pkg::CODE_LOCKED; // see R02 see R04
			end
		end
	end

	// Takes effect in the same cycle the response is raised
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bank_sel_q <= fwpbm_pkg::BANK_RESET;
		end else if (wr_fire && is_ctrl(awaddr_q) && wstrb_q[0]) begin
			bank_sel_q <= wdata_q[fwpbm_pkg::BANK_BIT]; // see R16 see R12
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	assign s_axi_arready = !rvalid_q;

	// Bits 2..0 carry no defined value; zero is returned
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= fwpbm_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rresp_q <= fwpbm_pkg::RESP_OKAY;
			if (is_ctrl(s_axi_araddr)) begin
				rdata_q <= {24'h00_0000, unlock_code_q, bank_sel_q, 3'h0}; // see R08
			end else if (is_stat(s_axi_araddr)) begin
				rdata_q <= {29'h0000_0000, mode_q};
			end else begin
				rdata_q <= 32'h0000_0000;
				rresp_q <= fwpbm_pkg::RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	////////////////////////////////////////////////////////////////////////
	// Address map
	fwpbm_map_if map_c();

	assign map_c.serial_mode = (mode_q == fwpbm_pkg::FWPBM_MODE_SERIAL); // see R07
	assign map_c.bank_sel = bank_sel_q;
	assign map_c.cpu_addr = cpu_addr;

	fwpbm_mapper u_mapper (
		.m(map_c)
	);

	assign flash_sel = map_c.hit_flash;
	assign rom_sel = map_c.hit_rom;
	assign flash_addr = map_c.flash_addr;

	////////////////////////////////////////////////////////////////////////
	// Command gate
	logic cmd_req;

	// Writes outside the mapped flash never reach the macro
	assign cmd_req = cpu_wr && map_c.hit_flash;

	fwpbm_cmd_gate u_gate (
		.unlocked(unlock_code_q == fwpbm_pkg::CODE_UNLOCKED), // see R01
		.parallel_mode(mode_q == fwpbm_pkg::FWPBM_MODE_PARALLEL), // see R14
		.wr_req(cmd_req),
		.wr_addr(map_c.flash_addr),
		.wr_data(cpu_wdata),
		.cmd_wr(flash_cmd_wr),
		.cmd_addr(flash_cmd_addr),
		.cmd_match(flash_cmd_match)
	);

	assign flash_cmd_data = cpu_wdata;
endmodule

// *** tb/fwpbm_assertions.sv ***
// Checker for the flash control top: bus timing, command gate and address map.
// Assumes a bind onto fwpbm_top, seeing its ports only.
module fwpbm_assertions (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// CPU access and flash side
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic [7:0] cpu_wdata,
	input wire logic flash_sel,
	input wire logic rom_sel,
	input wire logic [15:0] flash_addr,
	input wire logic flash_cmd_wr,
	input wire logic [11:0] flash_cmd_match,
	input wire logic [7:0] flash_cmd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write response late");
	rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	cmd_gate_a: assert property (flash_cmd_wr |-> cpu_wr && flash_sel && flash_cmd_data == cpu_wdata)
		else $error("command write without cause");
	cmd_match_a: assert property (flash_cmd_wr |-> flash_cmd_match == cpu_addr[11:0])
		else $error("command match bits wrong");
	rom_range_a: assert property (rom_sel |-> cpu_addr[15:11] == 5'h0f && !flash_sel)
		else $error("loader select out of range");
	low_hole_a: assert property (cpu_addr < 16'h1000 |-> !flash_sel && !rom_sel)
		else $error("select below flash base");
	map_rule_a: assert property (flash_sel |-> flash_addr >= 16'h1000 &&
		(flash_addr == cpu_addr || flash_addr == cpu_addr - 16'h8000))
		else $error("flash address mapping wrong");
	bank_low_a: assert property (flash_sel && flash_addr != cpu_addr |->
		cpu_addr >= 16'h9000 && flash_addr < 16'h8000) else $error("lower bank mapping wrong");
	// Main scenarios reached
	cover property (rom_sel);
	cover property (flash_cmd_wr);
	cover property (flash_sel && flash_addr != cpu_addr);
endmodule
////////////////////////////////////////////////////////////////
bind fwpbm_top fwpbm_assertions chk (.*);

// *** tb/fwpbm_cpu_model.sv ***
// CPU model: single-cycle flash access cycles toward the top.
// Assumes the bench calls access, checks, then rel.
module fwpbm_cpu_model (
	// Clock
	input wire logic clk,
	// Flash access
	output logic [15:0] addr,
	output logic wr,
	output logic [7:0] wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		addr = 16'h0000;
		wr = 1'b0;
		wdata = 8'h00;
	end
	task automatic access(input logic [15:0] a, input logic w, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wr <= w;
		wdata <= d;
		@(negedge clk);
	endtask
	// Released data inverts, so a stale value never matches
	task automatic rel;
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~wdata;
	endtask
endmodule

// *** tb/flash_write_protect_bank_map_bench.sv ***
// Bench for the flash control top: register bus, lock and bank map.
// Assumes the CPU model drives the flash access port.
module flash_write_protect_bank_map_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, serial_mode_pin, parallel_mode_pin, cpu_wr, flash_sel, rom_sel, flash_cmd_wr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, cpu_wdata, flash_cmd_data;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [15:0] cpu_addr, flash_addr, flash_cmd_addr;
	logic [11:0] flash_cmd_match;
	// Serial, bank, address, flash select, loader select, flash address
	logic [47:0] rows [9] = '{48'h0110_0010_1000, 48'h0078_0010_7800, 48'h010f_ff00_0000,
		48'h1078_0001_0000, 48'h1090_0010_1000, 48'h10ff_ff10_7fff, 48'h108f_ff00_0000,
		48'h1180_0010_8000, 48'h117f_ff01_0000};
	int miscompares = 0;
	int samples_checked = 0;
	fwpbm_top dut (.*);
	fwpbm_cpu_model cpu (.clk(clk), .addr(cpu_addr), .wr(cpu_wr), .wdata(cpu_wdata));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		bit ad = 0;
		bit wd = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (s_axi_awready) ad = 1;
			if (s_axi_wready) wd = 1;
			s_axi_awvalid <= !ad;
			s_axi_wvalid <= !wd;
		end
		while (!s_axi_bvalid) @(posedge clk);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Pins pass a synchroniser, so allow settling
	task automatic mode(input logic s, input logic p);
		serial_mode_pin <= s;
		parallel_mode_pin <= p;
		repeat (5) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		{serial_mode_pin, parallel_mode_pin, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		axr(8'h00);
		chk(rd, 32'h0000_00c0);
		axr(8'h04);
		chk(rd, 32'h0000_0001);
		axr(8'h08);
		chk(rsp, 2'h2);
		axw(8'h00, 32'h0000_0030);
		chk(rsp, 2'h0);
		cpu.access(16'h1555, 1'b1, 8'haa);
		chk({flash_cmd_wr, flash_cmd_match, flash_cmd_data}, {1'b1, 12'h555, 8'haa});
		chk(flash_cmd_addr, 16'h1555);
		cpu.rel();
		axw(8'h00, 32'h0000_00c0);
		cpu.access(16'h1aaa, 1'b1, 8'h55);
		chk(flash_cmd_wr, 1'b0);
		cpu.rel();
		foreach (rows[i]) begin
			mode(rows[i][44], 1'b0);
			axw(8'h00, {24'h0, 4'hc, rows[i][40], 3'h0});
			cpu.access(rows[i][39:24], 1'b0, 8'h00);
			chk({flash_sel, rom_sel}, {rows[i][20], rows[i][16]});
			if (rows[i][20]) chk(flash_addr, rows[i][15:0]);
			cpu.rel();
		end
		axr(8'h04);
		chk(rd, 32'h0000_0002);
		axw(8'h00, 32'h0000_0030);
		cpu.access(16'hf555, 1'b1, 8'h80);
		chk({flash_cmd_wr, flash_cmd_addr}, {1'b1, 16'h7555});
		cpu.rel();
		mode(1'b0, 1'b1);
		cpu.access(16'h1555, 1'b1, 8'haa);
		chk(flash_cmd_wr, 1'b0);
		cpu.rel();
		// Mid-run reset must relock and clear the bank select
		axw(8'h00, 32'h0000_0038);
		rst <= 1'b1;
		mode(1'b0, 1'b0);
		rst <= 1'b0;
		axr(8'h00);
		chk(rd, 32'h0000_00c0);
		cpu.access(16'h1555, 1'b1, 8'haa);
		chk(flash_cmd_wr, 1'b0);
		cpu.rel();
		conclude();
	end
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		conclude();
	end
endmodule
